// ### core/rqc_map.svh
`ifndef RQC_MAP_SVH
`define RQC_MAP_SVH
`define RQC_NQ      4
`define RQC_TW      24
`define RQC_WIN     16
`define RQC_WIX     4
`define RQC_CRW     5
`define RQC_XIDW    16
`define RQC_TZERO   24'h000000
`define RQC_TONE    24'h000001
`define RQC_BZERO   16'h0000
`define RQC_BONE    16'h0001
`define RQC_CZERO   5'h00
`define RQC_XIDZERO 16'h0000
`define RQC_XIDONE  16'h0001
`endif

// ### core/rqc_pkg.sv
package rqc_pkg;
    // identifier range of an aborted sequence
    typedef struct packed {
        logic [15:0] ox_id;
        logic [7:0]  seq_id;
        logic [15:0] cnt_lo;
        logic [15:0] cnt_hi;
        logic        initiator;
    } rqc_qual_t;

    // header fields of a received frame
    typedef struct packed {
        logic [15:0] ox_id;
        logic [7:0]  seq_id;
        logic [15:0] seq_cnt;
        logic        is_data;
        logic        is_lc;
        logic        first_seq;
        logic        last_seq;
        logic        last_frame;
        logic        conn_start;
        logic [31:0] assoc;
    } rqc_rxhdr_t;

    // parameters handed to the upper layer
    typedef struct packed {
        logic [31:0] assoc;
        logic [63:0] name;
        logic [15:0] xid;
    } rqc_ul_t;

    typedef enum logic [1:0] {
        RQC_ST_IDLE  = 2'b00,
        RQC_ST_HOLD  = 2'b01,
        RQC_ST_READY = 2'b10
    } rqc_state_t;
endpackage : rqc_pkg

// ### core/rqc_qtimer.sv
`timescale 1ns/1ps
`include "rqc_map.svh"
// one qualifier slot countdown
module rqc_qtimer
    import rqc_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              load_i,
    input  wire logic [`RQC_TW-1:0] value_i,
    output logic                    active_o
);
    logic [`RQC_TW-1:0] count;

    // the slot lives while the count is nonzero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= `RQC_TZERO;
        end else if (load_i) begin
            count <= value_i;
        end else if (count != `RQC_TZERO) begin
            count <= count - `RQC_TONE;
        end
    end

    assign active_o = (count != `RQC_TZERO);
endmodule : rqc_qtimer

// ### core/rqc_top.sv
`timescale 1ns/1ps
`include "rqc_map.svh"
module rqc_top
    import rqc_pkg::*;
(
    input  wire logic                 MCLK_I,
    input  wire logic                 RST_I,
    input  wire logic [`RQC_TW-1:0]   RATOV_CYC_I,
    input  wire logic [`RQC_TW-1:0]   EDTOV_CYC_I,
    input  wire logic                 INIT_DONE_I,
    input  wire logic                 ORDERED_ACK_I,
    input  wire logic                 INTERMIX_I,
    input  wire logic [63:0]          LOCAL_NAME_I,
    input  wire logic                 ABORT_I,
    input  wire rqc_qual_t            ABORT_QUAL_I,
    input  wire logic                 TX_REQ_I,
    input  wire rqc_qual_t            TX_QUAL_I,
    input  wire logic [`RQC_CRW-1:0]  CREDIT_I,
    input  wire logic                 TX_FRM_I,
    input  wire logic [`RQC_WIX-1:0]  TX_FRM_CNT_I,
    input  wire logic                 ACK_IN_I,
    input  wire logic [`RQC_WIX-1:0]  ACK_IN_CNT_I,
    input  wire logic                 RX_VLD_I,
    input  wire rqc_rxhdr_t           RX_HDR_I,
    input  wire logic                 RX_BUF_AVAIL_I,
    input  wire logic                 TERM_I,
    input  wire logic [`RQC_XIDW-1:0] TERM_OXID_I,
    output logic                      START_OK_O,
    output logic                      TX_GNT_O,
    output logic                      TX_CREDIT_OK_O,
    output logic                      QL_FULL_O,
    output logic                      RX_PASS_O,
    output logic                      RX_DROP_O,
    output logic                      RX_BUSY_O,
    output logic                      ACK_OUT_O,
    output logic [`RQC_WIX-1:0]       ACK_OUT_CNT_O,
    output logic                      SEQ_DONE_O,
    output logic                      SEQ_TMO_O,
    output logic                      UL_OPEN_O,
    output logic                      UL_CLOSE_O,
    output rqc_ul_t                   UL_INFO_O,
    output logic                      OXID_REL_O,
    output logic [`RQC_XIDW-1:0]      OXID_REL_VAL_O
);
    //**************************************************************
    // startup hold
    //**************************************************************
    rqc_state_t          state;
    rqc_state_t          next_state;
    logic [`RQC_TW-1:0]  hold_cnt;
    wire                 hold_end = (hold_cnt == `RQC_TONE);

    // old frames from before init may still be in the fabric
    always_comb begin
        next_state = state;
        case (state)
            RQC_ST_IDLE:  if (INIT_DONE_I) next_state = RQC_ST_HOLD;
            // a fresh init in the last hold cycle restarts the wait instead
            RQC_ST_HOLD:  if (hold_end && !INIT_DONE_I) next_state = RQC_ST_READY;
            RQC_ST_READY: if (INIT_DONE_I) next_state = RQC_ST_HOLD;
            default:      next_state = RQC_ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            state    <= RQC_ST_IDLE;
            hold_cnt <= `RQC_TZERO;
        end else begin
            state <= next_state;
            if (INIT_DONE_I) begin
                hold_cnt <= RATOV_CYC_I;
            end else if (hold_cnt != `RQC_TZERO) begin
                hold_cnt <= hold_cnt - `RQC_TONE;
            end
        end
    end

    assign START_OK_O = (state == RQC_ST_READY);

    //**************************************************************
    // recovery qualifier list
    //**************************************************************
    rqc_qual_t             qual [`RQC_NQ];
    logic [`RQC_NQ-1:0]    q_act;
    logic [`RQC_NQ-1:0]    q_load;
    logic [`RQC_NQ-1:0]    hit_tx;
    logic [`RQC_NQ-1:0]    hit_rx;
    logic [`RQC_NQ-1:0]    free_one;

    // lowest free slot takes the new entry; full list refuses it
    assign free_one = ~q_act & (q_act + `RQC_NQ'(1));
    assign q_load   = ABORT_I ? free_one : '0;
    assign QL_FULL_O = &q_act;

    genvar gi;
    generate
        for (gi = 0; gi < `RQC_NQ; gi = gi + 1) begin : g_q
            rqc_qtimer u_tmr (
                .clk_i    (MCLK_I),
                .rst_i    (RST_I),
                .load_i   (q_load[gi]),
                .value_i  (RATOV_CYC_I),
                .active_o (q_act[gi])
            );

            always_ff @(posedge MCLK_I) begin
                if (RST_I) begin
                    qual[gi] <= '0;
                end else if (q_load[gi]) begin
                    qual[gi] <= ABORT_QUAL_I;
                end
            end

            // range overlap for a transmit, point hit for a received frame
            assign hit_tx[gi] = q_act[gi] &&
                                (TX_QUAL_I.ox_id == qual[gi].ox_id) &&
                                (TX_QUAL_I.seq_id == qual[gi].seq_id) &&
                                (TX_QUAL_I.cnt_lo <= qual[gi].cnt_hi) &&
                                (TX_QUAL_I.cnt_hi >= qual[gi].cnt_lo);
            assign hit_rx[gi] = q_act[gi] &&
                                (RX_HDR_I.ox_id == qual[gi].ox_id) &&
                                (RX_HDR_I.seq_id == qual[gi].seq_id) &&
                                (RX_HDR_I.seq_cnt >= qual[gi].cnt_lo) &&
                                (RX_HDR_I.seq_cnt <= qual[gi].cnt_hi) &&
                                ((qual[gi].initiator & RX_HDR_I.is_lc) |
                                 (~qual[gi].initiator & RX_HDR_I.is_data));
        end
    endgenerate

    // grant is combinational so the sequencer can start in the same cycle
    assign TX_GNT_O = TX_REQ_I && START_OK_O && !(|hit_tx);

    //**************************************************************
    // transmit credit
    //**************************************************************
    logic [`RQC_WIN-1:0] out_bits;
    logic [`RQC_TW-1:0]  ed_cnt;
    logic [`RQC_WIN-1:0] ack_clr;
    logic [`RQC_WIN-1:0] le_mask;

    function automatic logic [`RQC_CRW-1:0] rqc_pop(input logic [`RQC_WIN-1:0] v);
        logic [`RQC_CRW-1:0] n;
        n = `RQC_CZERO;
        for (int k = 0; k < `RQC_WIN; k++) begin
            n = n + `RQC_CRW'(v[k]);
        end
        return n;
    endfunction : rqc_pop

    assign le_mask = (`RQC_BONE << ACK_IN_CNT_I) | ((`RQC_BONE << ACK_IN_CNT_I) - `RQC_BONE);
    assign ack_clr = !ACK_IN_I     ? `RQC_BZERO :
                     ORDERED_ACK_I ? le_mask :
                                     (`RQC_BONE << ACK_IN_CNT_I);
    wire ed_exp = (out_bits != `RQC_BZERO) && (ed_cnt == `RQC_TONE);
    // a frame sent in the expiry cycle still takes its credit
    wire [`RQC_WIN-1:0] frm_set = TX_FRM_I ? (`RQC_BONE << TX_FRM_CNT_I) : `RQC_BZERO;
    assign TX_CREDIT_OK_O = (rqc_pop(out_bits) < CREDIT_I);

    // a lost misordered ack keeps its credit until the error timer fires
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            out_bits  <= `RQC_BZERO;
            ed_cnt    <= `RQC_TZERO;
            SEQ_TMO_O <= 1'b0;
        end else begin
            SEQ_TMO_O <= ed_exp;
            if (ed_exp) begin
                out_bits <= frm_set;
            end else begin
                out_bits <= (out_bits & ~ack_clr) | frm_set;
            end
            // rearm on expiry so a frame sent in that cycle can still time out
            if (ACK_IN_I || ed_exp || (TX_FRM_I && out_bits == `RQC_BZERO)) begin
                ed_cnt <= EDTOV_CYC_I;
            end else if (ed_cnt != `RQC_TZERO) begin
                ed_cnt <= ed_cnt - `RQC_TONE;
            end
        end
    end

    //**************************************************************
    // receive filter, reassembly and ack ordering
    //**************************************************************
    logic [`RQC_WIN-1:0] rx_bits;
    logic [`RQC_WIX-1:0] ack_ptr;
    logic [`RQC_WIX-1:0] last_idx;
    logic                last_seen;
    logic [`RQC_XIDW-1:0] rx_id_next;
    wire  [`RQC_WIX-1:0] rx_idx  = RX_HDR_I.seq_cnt[`RQC_WIX-1:0];
    wire                 drop    = RX_VLD_I && (|hit_rx);
    // stale frames may hold buffers; connect-start is never busied
    wire                 busy    = RX_VLD_I && !drop && !RX_BUF_AVAIL_I &&
                                   INTERMIX_I && !RX_HDR_I.conn_start;
    wire                 take    = RX_VLD_I && !drop && !busy;
    wire [`RQC_WIN-1:0]  bits_nx = rx_bits | (take && RX_HDR_I.is_data ?
                                   (`RQC_BONE << rx_idx) : `RQC_BZERO);
    wire                 lst_nx  = last_seen | (take && RX_HDR_I.last_frame);
    wire [`RQC_WIX-1:0]  lidx_nx = (take && RX_HDR_I.last_frame) ? rx_idx : last_idx;
    wire [`RQC_WIN-1:0]  need    = (`RQC_BONE << lidx_nx) |
                                   ((`RQC_BONE << lidx_nx) - `RQC_BONE);
    wire                 ord_ack = ORDERED_ACK_I && rx_bits[ack_ptr] && !SEQ_DONE_O;
    wire                 acks_ok = !ORDERED_ACK_I ||
                                   (ord_ack && ack_ptr == last_idx);
    wire                 done    = lst_nx && ((bits_nx & need) == need) && acks_ok;

    // ordered mode walks the pointer so acks leave in count order
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            rx_bits       <= `RQC_BZERO;
            ack_ptr       <= '0;
            last_idx      <= '0;
            last_seen     <= 1'b0;
            ACK_OUT_O     <= 1'b0;
            ACK_OUT_CNT_O <= '0;
            SEQ_DONE_O    <= 1'b0;
        end else begin
            SEQ_DONE_O <= done;
            rx_bits    <= done ? `RQC_BZERO : bits_nx;
            last_seen  <= done ? 1'b0 : lst_nx;
            last_idx   <= done ? '0 : lidx_nx;
            if (ORDERED_ACK_I) begin
                ACK_OUT_O     <= ord_ack;
                ACK_OUT_CNT_O <= ack_ptr;
                if (done) begin
                    ack_ptr <= '0;
                end else if (ord_ack) begin
                    ack_ptr <= ack_ptr + `RQC_WIX'(1);
                end
            end else begin
                ACK_OUT_O     <= take && RX_HDR_I.is_data;
                ACK_OUT_CNT_O <= rx_idx;
                ack_ptr       <= '0;
            end
        end
    end

    //**************************************************************
    // upper-layer reporting and exchange release
    //**************************************************************
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            RX_PASS_O      <= 1'b0;
            RX_DROP_O      <= 1'b0;
            RX_BUSY_O      <= 1'b0;
            UL_OPEN_O      <= 1'b0;
            UL_CLOSE_O     <= 1'b0;
            UL_INFO_O      <= '0;
            OXID_REL_O     <= 1'b0;
            OXID_REL_VAL_O <= `RQC_XIDZERO;
            rx_id_next     <= `RQC_XIDONE;
        end else begin
            RX_PASS_O  <= take;
            RX_DROP_O  <= drop;
            RX_BUSY_O  <= busy;
            UL_OPEN_O  <= take && RX_HDR_I.first_seq;
            UL_CLOSE_O <= take && RX_HDR_I.last_seq && !RX_HDR_I.first_seq;
            if (take && RX_HDR_I.first_seq) begin
                UL_INFO_O  <= '{assoc: RX_HDR_I.assoc, name: LOCAL_NAME_I,
                                xid: rx_id_next};
                rx_id_next <= rx_id_next + `RQC_XIDONE;
            end else if (take && RX_HDR_I.last_seq) begin
                UL_INFO_O <= '{assoc: RX_HDR_I.assoc, name: LOCAL_NAME_I,
                               xid: RX_HDR_I.ox_id};
            end
            // local terminate wins over a remote close in the same cycle
            OXID_REL_O <= TERM_I || (take && RX_HDR_I.last_seq &&
                                     !RX_HDR_I.first_seq);
            OXID_REL_VAL_O <= TERM_I ? TERM_OXID_I : RX_HDR_I.ox_id;
        end
    end
endmodule : rqc_top

// ### dv/rqc_assertions.sv
`timescale 1ns/1ps
`include "rqc_map.svh"
// ****
// rqc checker
// ****
module rqc_assertions
    import rqc_pkg::*;
(
    input wire logic        MCLK_I,
    input wire logic        RST_I,
    input wire logic        INIT_DONE_I,
    input wire logic        INTERMIX_I,
    input wire logic [63:0] LOCAL_NAME_I,
    input wire logic        ORDERED_ACK_I,
    input wire logic        TX_REQ_I,
    input wire logic        RX_VLD_I,
    input wire rqc_rxhdr_t  RX_HDR_I,
    input wire logic        TERM_I,
    input wire logic [15:0] TERM_OXID_I,
    input wire logic        START_OK_O,
    input wire logic        TX_GNT_O,
    input wire logic        RX_PASS_O,
    input wire logic        RX_DROP_O,
    input wire logic        RX_BUSY_O,
    input wire logic        ACK_OUT_O,
    input wire logic [3:0]  ACK_OUT_CNT_O,
    input wire logic        UL_OPEN_O,
    input wire logic        UL_CLOSE_O,
    input wire rqc_ul_t     UL_INFO_O,
    input wire logic        OXID_REL_O,
    input wire logic [15:0] OXID_REL_VAL_O
);
    // one clock domain, reset masks everything
    default clocking @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);
    a_hold_no_grant: assert property (!START_OK_O |-> !TX_GNT_O)
        else $error("grant during startup hold");
    a_init_rearms: assert property (INIT_DONE_I |=> !START_OK_O)
        else $error("ready right after init");
    a_grant_has_req: assert property (TX_GNT_O |-> TX_REQ_I)
        else $error("grant without request");
    a_rx_one_result: assert property (RX_VLD_I |=> $onehot({RX_PASS_O, RX_DROP_O, RX_BUSY_O}))
        else $error("frame verdict not unique");
    a_rx_has_cause: assert property ((RX_PASS_O || RX_DROP_O || RX_BUSY_O) |-> $past(RX_VLD_I))
        else $error("verdict without frame");
    a_busy_exempt: assert property (RX_VLD_I && (RX_HDR_I.conn_start || !INTERMIX_I) |=> !RX_BUSY_O)
        else $error("busy on exempt frame");
    a_term_release: assert property (TERM_I |=> OXID_REL_O && OXID_REL_VAL_O == $past(TERM_OXID_I))
        else $error("exchange id not released");
    a_open_info: assert property (UL_OPEN_O |-> UL_INFO_O.name == $past(LOCAL_NAME_I)
        && UL_INFO_O.assoc == $past(RX_HDR_I.assoc))
        else $error("open info wrong");
    a_close_xid: assert property (UL_CLOSE_O |-> UL_INFO_O.xid == $past(RX_HDR_I.ox_id))
        else $error("close id wrong");
    a_ack_ascend: assert property (ORDERED_ACK_I && ACK_OUT_O ##1 ACK_OUT_O
        |-> ACK_OUT_CNT_O == $past(ACK_OUT_CNT_O) + 4'h1)
        else $error("ordered acks out of order");
endmodule : rqc_assertions
bind rqc_top rqc_assertions i_rqc_assertions (.*);

// ### dv/rqc_partner.sv
`timescale 1ns/1ps
// ****
// far side: fabric timeouts and remote acks
// ****
module rqc_partner (
    input  wire logic        clk_i,
    input  wire logic        tx_frm_i,
    input  wire logic [3:0]  tx_cnt_i,
    input  wire logic [15:0] lose_i,
    output logic [23:0]      ratov_o,
    output logic [23:0]      edtov_o,
    output logic             ack_o,
    output logic [3:0]       ack_cnt_o
);
    logic [2:0] dly = 3'h0;
    logic [3:0] pend = 4'h0;
    logic       a = 1'b0;
    logic [3:0] c = 4'h5;
    // short timeouts keep the run small; the port must use them as given
    assign ratov_o = 24'h000008;
    assign edtov_o = 24'h000010;
    assign ack_o = a;
    assign ack_cnt_o = c;
    // each frame not marked in lose_i acked after a short flight unless another unmarked frame follows within two cycles; count line toggles when idle
    always @(posedge clk_i) begin
        a <= dly == 3'h1;
        c <= dly == 3'h1 ? pend : ~c;
        if (tx_frm_i && !lose_i[tx_cnt_i]) begin
            dly <= 3'h3;
            pend <= tx_cnt_i;
        end else if (dly != 3'h0) begin
            dly <= dly - 3'h1;
        end
    end
endmodule : rqc_partner

// ### dv/testbench.sv
`timescale 1ns/1ps
`include "rqc_map.svh"
// ****
// rqc bench
// ****
module testbench;
    import rqc_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, init = 1'b0, ord = 1'b0, imix = 1'b0;
    logic        abrt = 1'b0, treq = 1'b0, tfrm = 1'b0, rvld = 1'b0, rbuf = 1'b1, term = 1'b0;
    logic [3:0]  tcnt = 4'h0, ackc, ackoc;
    logic [4:0]  cred = 5'h01;
    logic [15:0] toxid = 16'h0000, lose = 16'h0000, relv;
    logic [63:0] lname = 64'h0123456789ABCDEF;
    rqc_qual_t   aq = '0, tq = '0;
    rqc_rxhdr_t  hdr = '0, h;
    rqc_ul_t     uinfo;
    logic [23:0] ratov, edtov;
    logic        ack, sok, gnt, crok, qfull, pass, drop, busy, acko, sdone, stmo;
    logic        uopen, uclose, rel;
    logic [31:0] lfsr = 32'h606AC3F0;
    logic [9:0]  r, cor[4] = '{10'h08A, 10'h0F9, 10'h302, 10'h234};
    logic [3:0]  ackq[$], seqs[4] = '{4'h2, 4'h0, 4'h3, 4'h1};
    int          mismatches = 0, num_checks = 0, n, sdn = 0;
    always #10 clk = ~clk;
    rqc_top i_rqc_top (.MCLK_I(clk), .RST_I(rst), .RATOV_CYC_I(ratov), .EDTOV_CYC_I(edtov),
        .INIT_DONE_I(init), .ORDERED_ACK_I(ord), .INTERMIX_I(imix), .LOCAL_NAME_I(lname),
        .ABORT_I(abrt), .ABORT_QUAL_I(aq), .TX_REQ_I(treq), .TX_QUAL_I(tq), .CREDIT_I(cred),
        .TX_FRM_I(tfrm), .TX_FRM_CNT_I(tcnt), .ACK_IN_I(ack), .ACK_IN_CNT_I(ackc),
        .RX_VLD_I(rvld), .RX_HDR_I(hdr), .RX_BUF_AVAIL_I(rbuf), .TERM_I(term),
        .TERM_OXID_I(toxid), .START_OK_O(sok), .TX_GNT_O(gnt), .TX_CREDIT_OK_O(crok),
        .QL_FULL_O(qfull), .RX_PASS_O(pass), .RX_DROP_O(drop), .RX_BUSY_O(busy),
        .ACK_OUT_O(acko), .ACK_OUT_CNT_O(ackoc), .SEQ_DONE_O(sdone), .SEQ_TMO_O(stmo),
        .UL_OPEN_O(uopen), .UL_CLOSE_O(uclose), .UL_INFO_O(uinfo), .OXID_REL_O(rel),
        .OXID_REL_VAL_O(relv));
    rqc_partner i_rqc_partner (.clk_i(clk), .tx_frm_i(tfrm), .tx_cnt_i(tcnt), .lose_i(lose),
        .ratov_o(ratov), .edtov_o(edtov), .ack_o(ack), .ack_cnt_o(ackc));
    // outgoing acks and finished sequences, recorded for later comparison
    always @(posedge clk) begin
        if (acko === 1'b1) ackq.push_back(ackoc);
        if (sdone === 1'b1) sdn++;
    end
    function automatic logic [31:0] nxt(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    function automatic rqc_qual_t qu(logic [15:0] ox, lo, hi, logic ini);
        return '{ox, 8'h01, lo, hi, ini};
    endfunction : qu
    // verdict for a frame against entry 8..15; bits of v as in the stimulus word
    function automatic logic [2:0] exp_rx(logic [9:0] v);
        if (v[8:4] >= 5'h08 && v[8:4] <= 5'h0F && (v[0] ? !v[1] : v[1])) return 3'b010;
        if (!v[3] && v[9] && !v[2]) return 3'b001;
        return 3'b100;
    endfunction : exp_rx
    function automatic logic sig(int k);
        return k == 0 ? sok : stmo;
    endfunction : sig
    task automatic chk(logic [127:0] got, logic [127:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic tk(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tk
    // bounded wait for an output; running out ends the run
    task automatic wt(int k, int lim);
        n = 0;
        while (sig(k) !== 1'b1) begin
            tk(1);
            n++;
            if (n > lim) begin
                mismatches++;
                complete_run();
            end
        end
    endtask : wt
    task automatic rx(rqc_rxhdr_t f);
        @(posedge clk);
        rvld <= 1'b1;
        hdr <= f;
        @(posedge clk);
        rvld <= 1'b0;
        #1;
    endtask : rx
    task automatic frm(logic [3:0] c, logic [15:0] ls);
        @(posedge clk);
        tfrm <= 1'b1;
        tcnt <= c;
        lose <= ls;
        @(posedge clk);
        tfrm <= 1'b0;
    endtask : frm
    task automatic done(string s);
        $display("test %s finished at %0t", s, $time);
    endtask : done
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        tk(1);
        chk(sok, 0);
        // startup hold with a request already waiting
        @(posedge clk);
        init <= 1'b1;
        treq <= 1'b1;
        tq <= qu(16'h0005, 16'h0006, 16'h0009, 1'b0);
        @(posedge clk);
        init <= 1'b0;
        #1;
        chk(gnt, 0);
        wt(0, 40);
        chk(n, 8);
        chk(gnt, 1);
        done("startup");
        // four aborts back to back fill the list; two of them overlap the request
        @(posedge clk);
        abrt <= 1'b1;
        aq <= qu(16'h0005, 16'h0004, 16'h0007, 1'b0);
        @(posedge clk);
        aq <= qu(16'h0005, 16'h0008, 16'h000B, 1'b1);
        @(posedge clk);
        aq <= qu(16'h0009, 16'h0000, 16'h0000, 1'b0);
        repeat (2) @(posedge clk);
        abrt <= 1'b0;
        #1;
        chk({qfull, gnt}, 2'b10);
        tk(4);
        chk(qfull, 1);
        tk(1);
        chk({qfull, gnt}, 2'b00);
        tk(1);
        chk(gnt, 1);
        done("qualifier");
        // ordered mode, frames arrive shuffled
        @(posedge clk);
        ord <= 1'b1;
        foreach (seqs[i]) begin
            h = '0;
            h.ox_id = 16'h0003;
            h.is_data = 1'b1;
            h.seq_cnt = {12'h000, seqs[i]};
            h.last_frame = seqs[i] == 4'h3;
            rx(h);
        end
        tk(8);
        chk(ackq.size(), 4);
        foreach (ackq[i]) chk(ackq[i], i);
        chk(sdn, 1);
        done("reassembly");
        // credit of one: a later ack covers a lost one only in ordered mode
        frm(4'h0, 16'h0001);
        tk(6);
        chk(crok, 0);
        frm(4'h1, 16'h0001);
        tk(6);
        chk(crok, 1);
        @(posedge clk);
        ord <= 1'b0;
        frm(4'h0, 16'h0001);
        frm(4'h1, 16'h0001);
        tk(6);
        chk(crok, 0);
        wt(1, 40);
        // error timer reloads with 16 at the ack, two of those cycles already waited
        chk(n, 14);
        tk(1);
        chk(crok, 1);
        done("credit");
        // corner frames first, then random ones, each against a fresh entry
        for (int k = 0; k < 16; k++) begin
            lfsr = nxt(lfsr);
            r = k < 4 ? cor[k] : lfsr[9:0];
            @(posedge clk);
            abrt <= 1'b1;
            aq <= qu(16'h0007, 16'h0008, 16'h000F, r[0]);
            @(posedge clk);
            abrt <= 1'b0;
            rbuf <= r[3];
            imix <= r[9];
            h = '0;
            h.ox_id = 16'h0007;
            h.seq_id = 8'h01;
            h.seq_cnt = {11'h000, r[8:4]};
            h.is_data = r[1];
            h.is_lc = !r[1];
            h.conn_start = r[2];
            rx(h);
            chk({pass, drop, busy}, exp_rx(r));
            tk(9);
        end
        done("receive");
        // operation open, remote close, local terminate
        @(posedge clk);
        rbuf <= 1'b1;
        h = '0;
        h.ox_id = 16'h0042;
        h.is_lc = 1'b1;
        h.first_seq = 1'b1;
        h.assoc = lfsr;
        rx(h);
        chk({uopen, uinfo}, {1'b1, lfsr, lname, 16'h0001});
        h.first_seq = 1'b0;
        h.last_seq = 1'b1;
        rx(h);
        chk({uclose, uinfo, rel}, {1'b1, lfsr, lname, 16'h0042, 1'b1});
        chk(relv, 16'h0042);
        @(posedge clk);
        term <= 1'b1;
        toxid <= lfsr[31:16];
        @(posedge clk);
        term <= 1'b0;
        #1;
        chk({rel, relv}, {1'b1, lfsr[31:16]});
        done("operation");
        complete_run();
    end
endmodule : testbench
